// ---- shared/vip_map.vh ----
// Register map, field positions and reset values of the interrupt resolver.
// Included by the picker and top-level design files; holds definitions only.
`ifndef VIP_MAP_VH
`define VIP_MAP_VH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define VIP_OFF_ENABLE 8'h00
`define VIP_OFF_FLAG 8'h04
`define VIP_OFF_LEVEL 8'h08
`define VIP_OFF_CTRL0 8'h0C
`define VIP_OFF_CTRL1 8'h10
`define VIP_OFF_WORKING_REGISTER 8'h14
`define VIP_OFF_RETURN 8'h18
`define VIP_OFF_ISTAT 8'h1C
`define VIP_OFF_IMASK 8'h20
`define VIP_OFF_SUMSRC 8'h24

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define VIP_CTRL0_GIEL 0
`define VIP_CTRL0_GIEH 1
`define VIP_CTRL1_STAT_LO 0
`define VIP_ISTAT_TAKE 0
`define VIP_ISTAT_RET 1
`define VIP_RET_KICK 0

// ---------------------------------------------------------------
// Reset values and codes
// ---------------------------------------------------------------
`define VIP_ENABLE_RST 8'h00
`define VIP_LEVEL_RST 8'hFF
`define VIP_AUTOCLR_MASK 8'h01
`define VIP_SUMMARY_MASK 8'h80
`define VIP_NSRC 8
`define VIP_STAT_MAIN 2'h0
`define VIP_STAT_LOW 2'h1
`define VIP_STAT_HIGH 2'h2
`define VIP_STAT_HIGH_FROM_LOW 2'h3
`define VIP_RESP_OKAY 2'h0
`define VIP_RESP_SLVERR 2'h2

`endif

// ---- core/vip_natural_pick.v ----
// Fixed-order picker: lowest set bit of a request vector wins.
// Pure combinational; the caller registers the result.
`timescale 1ns/1ps
`include "vip_map.vh"

module vip_natural_pick (
   // Requests, bit n is vector n
   input wire [7:0] req,
   // Result
   output reg found,
   output reg [2:0] vec
);
   integer i;

   always @* begin
      found = 1'b0;
      vec = 3'h0;
      // Descending loop so the smallest index is written last
      for (i = `VIP_NSRC - 1; i >= 0; i = i - 1) begin
         if (req[i]) begin
            found = 1'b1;
            vec = i[2:0];
         end
      end
   end
endmodule

// ---- core/vip_flag_bit.v ----
// One pending flag: hardware set beats every clear in the same cycle.
// Same-clock inputs only.
`timescale 1ns/1ps

module vip_flag_bit (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Controls
   input wire set,
   input wire clr,
   // State
   output reg flag
);
   always @(posedge aclk) begin
      if (!aresetn) begin
         flag <= 1'b0;
      end else if (set) begin
         flag <= 1'b1;
      end else if (clr) begin
         flag <= 1'b0;
      end
   end
endmodule

// ---- core/vip_top.v ----
// Vectored interrupt resolver with AXI4-Lite register access.
// Assumes event sources pulse on aclk, summary sources hold a level, and the core pulses a return strobe.
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "vip_map.vh"

module vip_top (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write address
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Source events, bit n is vector n for bits 0 to 6; bit 7 is ignored
   input wire [7:0] src_event,
   // Summary source levels (bit 7 used)
   input wire [7:0] src_summary,
   // Core handshake
   input wire isr_return,
   output reg vector_take,
   output reg [6:0] vector_num,
   output reg vector_high,
   output reg [7:0] working_register,
   // Interrupt to software
   output reg irq
);

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   reg [7:0] system_source_irq_enable;
   reg [7:0] level_select_regs;
   reg [1:0] global_irq_enables;
   reg [1:0] exec_state;
   reg [1:0] istat;
   reg [1:0] imask;
   reg [7:0] sum_latched;
   wire [7:0] interrupt_flag_regs;

   // Write channel capture
   reg aw_held;
   reg w_held;
   reg [7:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   wire wr_fire = aw_held && w_held && !s_axi_bvalid;
   wire wr_lane0 = wr_fire && w_strb[0];

   // ---------------------------------------------------------------
   // Flags
   // ---------------------------------------------------------------
   reg [7:0] flag_clr;
   reg [7:0] take_clr;
   wire [7:0] flag_set = src_event & ~`VIP_SUMMARY_MASK;

   genvar g;
   generate
      for (g = 0; g < 7; g = g + 1) begin : gen_flag
         vip_flag_bit u_flag (
            .aclk(aclk),
            .aresetn(aresetn),
            .set(flag_set[g]),
            .clr(flag_clr[g] | take_clr[g]),
            .flag(interrupt_flag_regs[g])
         );
      end
   endgenerate
   // Read-only summary, clears only once the source side drops
   assign interrupt_flag_regs[7] = sum_latched[7];

   always @(posedge aclk) begin
      if (!aresetn) begin
         sum_latched <= 8'h00;
      end else begin
         sum_latched <= src_summary & `VIP_SUMMARY_MASK;
      end
   end

   always @* begin
      flag_clr = 8'h00;
      if (wr_lane0 && aw_addr == `VIP_OFF_FLAG) begin
         flag_clr = ~w_data[7:0] & ~`VIP_SUMMARY_MASK;
      end
   end

   // ---------------------------------------------------------------
   // Resolution
   // ---------------------------------------------------------------
   wire [7:0] armed = interrupt_flag_regs & system_source_irq_enable;
   wire [7:0] req_hi = armed & level_select_regs &
                       {8{global_irq_enables[`VIP_CTRL0_GIEH]}};
   wire [7:0] req_lo = armed & ~level_select_regs &
                       {8{global_irq_enables[`VIP_CTRL0_GIEL]}};
   wire hi_found;
   wire lo_found;
   wire [2:0] hi_vec;
   wire [2:0] lo_vec;

   vip_natural_pick u_pick_hi (
      .req(req_hi),
      .found(hi_found),
      .vec(hi_vec)
   );
   vip_natural_pick u_pick_lo (
      .req(req_lo),
      .found(lo_found),
      .vec(lo_vec)
   );

   // High level checked first, whatever its vector
   wire take_hi = hi_found && (exec_state == `VIP_STAT_MAIN ||
                  exec_state == `VIP_STAT_LOW);
   wire take_lo = !take_hi && lo_found && exec_state == `VIP_STAT_MAIN;
   wire [2:0] win_vec = take_hi ? hi_vec : lo_vec;
   wire [7:0] win_onehot = 8'h01 << win_vec;
   wire enable_write = wr_lane0 && aw_addr == `VIP_OFF_CTRL0;
   wire ret_write = wr_lane0 && aw_addr == `VIP_OFF_RETURN &&
                    w_data[`VIP_RET_KICK];

   always @* begin
      take_clr = 8'h00;
      if ((take_hi || take_lo) && !enable_write) begin
         take_clr = win_onehot & `VIP_AUTOCLR_MASK;
      end
   end

   // ---------------------------------------------------------------
   // Execution state
   // ---------------------------------------------------------------
   reg [1:0] next_exec_state;
   wire do_return = isr_return || ret_write;

   always @* begin
      next_exec_state = exec_state;
      if (enable_write) begin
         next_exec_state = `VIP_STAT_MAIN;
      end else if (take_hi) begin
         next_exec_state = (exec_state == `VIP_STAT_LOW) ?
                           `VIP_STAT_HIGH_FROM_LOW : `VIP_STAT_HIGH;
      end else if (take_lo) begin
         next_exec_state = `VIP_STAT_LOW;
      end else if (do_return) begin
         case (exec_state)
            `VIP_STAT_HIGH_FROM_LOW: next_exec_state = `VIP_STAT_LOW;
            `VIP_STAT_HIGH: next_exec_state = `VIP_STAT_MAIN;
            `VIP_STAT_LOW: next_exec_state = `VIP_STAT_MAIN;
            default: next_exec_state = `VIP_STAT_MAIN;
         endcase
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         exec_state <= `VIP_STAT_MAIN;
         vector_take <= 1'b0;
         vector_num <= 7'h00;
         vector_high <= 1'b0;
         working_register <= 8'h00;
      end else begin
         exec_state <= next_exec_state;
         // Take held off in a cycle where software writes CTRL0; the flag stays pending
         vector_take <= (take_hi || take_lo) && !enable_write;
         if ((take_hi || take_lo) && !enable_write) begin
            vector_num <= {4'h0, win_vec};
            vector_high <= take_hi;
            working_register <= {5'h00, win_vec};
         end
      end
   end

   // ---------------------------------------------------------------
   // Software registers and status
   // ---------------------------------------------------------------
   wire [1:0] ev = {do_return && exec_state != `VIP_STAT_MAIN,
                    (take_hi || take_lo) && !enable_write};

   always @(posedge aclk) begin
      if (!aresetn) begin
         system_source_irq_enable <= `VIP_ENABLE_RST;
         level_select_regs <= `VIP_LEVEL_RST;
         global_irq_enables <= 2'h0;
         istat <= 2'h0;
         imask <= 2'h0;
      end else begin
         // Set beats write-one-clear
         istat <= ev | (istat & ~((wr_lane0 && aw_addr == `VIP_OFF_ISTAT) ?
                  w_data[1:0] : 2'h0));
         if (wr_lane0) begin
            case (aw_addr)
               `VIP_OFF_ENABLE: system_source_irq_enable <= w_data[7:0];
               `VIP_OFF_LEVEL: level_select_regs <= w_data[7:0];
               // Only software writes these, never the take path
               `VIP_OFF_CTRL0: global_irq_enables <= w_data[1:0];
               `VIP_OFF_IMASK: imask <= w_data[1:0];
               default: imask <= imask;
            endcase
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(istat & imask);
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite write path
   // ---------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `VIP_RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_held && !s_axi_awready;
         s_axi_wready <= !w_held && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr[1:0] != 2'h0 || aw_addr > `VIP_OFF_SUMSRC ||
                           aw_addr == `VIP_OFF_WORKING_REGISTER || aw_addr == `VIP_OFF_CTRL1) ?
                           `VIP_RESP_SLVERR : `VIP_RESP_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite read path
   // ---------------------------------------------------------------
   reg [31:0] rd_mux;
   reg rd_err;

   always @* begin
      rd_mux = 32'h0;
      rd_err = 1'b0;
      case (s_axi_araddr)
         `VIP_OFF_ENABLE: rd_mux = {24'h0, system_source_irq_enable};
         `VIP_OFF_FLAG: rd_mux = {24'h0, interrupt_flag_regs};
         `VIP_OFF_LEVEL: rd_mux = {24'h0, level_select_regs};
         `VIP_OFF_CTRL0: rd_mux = {30'h0, global_irq_enables};
         `VIP_OFF_CTRL1: rd_mux = {30'h0, exec_state};
         `VIP_OFF_WORKING_REGISTER: rd_mux = {24'h0, working_register};
         `VIP_OFF_RETURN: rd_mux = 32'h0;
         `VIP_OFF_ISTAT: rd_mux = {30'h0, istat};
         `VIP_OFF_IMASK: rd_mux = {30'h0, imask};
         `VIP_OFF_SUMSRC: rd_mux = {24'h0, sum_latched};
         default: rd_err = 1'b1;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `VIP_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_err ? `VIP_RESP_SLVERR : `VIP_RESP_OKAY;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

// ---- verification/vip_checker.sv ----
// Port checker for the interrupt resolver, bound to vip_top.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps

module vip_checker (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Core side
   input wire logic vector_take,
   input wire logic [6:0] vector_num,
   input wire logic vector_high,
   input wire logic [7:0] working_register,
   input wire logic irq
);
   // ----------
   // Properties
   // ----------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   working_register_match_a: assert property (vector_take |-> working_register == {1'b0, vector_num})
      else $error("working register differs");
   vec_hold_a: assert property (!vector_take |-> $stable({vector_num, working_register}))
      else $error("vector moved without take");
   vec_range_a: assert property (vector_take |-> vector_num < 7'h08)
      else $error("vector out of table");
   low_single_a: assert property (vector_take && !vector_high |=> !vector_take || vector_high)
      else $error("low take in low handler");
   high_block_a: assert property (vector_take && vector_high |=> !vector_take)
      else $error("take in high handler");
   wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
      else $error("read answer late");
   rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   cover property (vector_take && vector_high);
   cover property (vector_take && !vector_high);
   cover property (s_axi_rvalid && !s_axi_rready);
   cover property ($rose(irq));
endmodule

bind vip_top vip_checker chk_i (.*);

// ---- verification/vip_core_model.sv ----
// Core and source model facing the interrupt resolver.
// Assumes bench commands change just after a rising edge.
`timescale 1ns/1ps

module vip_core_model (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bench commands
   input wire logic [7:0] fire,
   input wire logic sum_on,
   input wire logic ret_req,
   input wire logic [3:0] ret_dly,
   // Resolver side
   output logic [7:0] src_event,
   output logic [7:0] src_summary,
   output logic isr_return
);
   // ----------------
   // Sources, returns
   // ----------------
   logic [4:0] cnt;
   // Summary falls only once its own source is cleared
   assign src_summary = {sum_on, 7'h00};
   always @(posedge aclk) begin
      if (!aresetn) begin
         src_event <= 8'h00;
         isr_return <= 1'b0;
         cnt <= 5'h00;
      end else begin
         src_event <= fire;
         // Return waits for the bench: flags must be cleared first
         isr_return <= (cnt == 5'h01);
         if (ret_req)
            cnt <= {1'b0, ret_dly} + 5'h01;
         else if (cnt != 5'h00)
            cnt <= cnt - 5'h01;
      end
   end
endmodule

// ---- verification/tb_vectored_interrupt_priority.sv ----
// Bench: AXI4-Lite master, behavioural resolver model, core model.
// Assumes vip_checker binds itself to vip_top.
`timescale 1ns/1ps

module tb_vectored_interrupt_priority;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, fire = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF, ret_dly = 4'h0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, sum_on = 0, ret_req = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic vector_take, vector_high, irq, isr_return;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] src_event, src_summary, working_register;
   logic [6:0] vector_num;
   int err_total = 0, total_checks = 0, m_flag = 0, m_en, m_lvl = 255, m_gl = 0, m_st = 0;
   int stk[$];

   always #10 aclk = ~aclk;
   vip_top uut (.*);
   vip_core_model core (.aclk(aclk), .aresetn(aresetn), .fire(fire), .sum_on(sum_on),
      .ret_req(ret_req), .ret_dly(ret_dly), .src_event(src_event),
      .src_summary(src_summary), .isr_return(isr_return));

   // ------------
   // Shared tasks
   // ------------
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         err_total++;
         $display("MISMATCH %s expected %0h seen %0h", nm, e, s);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // High candidates outrank low ones; lowest vector wins within a level
   function automatic int pick();
      pick = -1;
      for (int i = 7; i >= 0; i--)
         if (m_flag[i] && m_en[i] && !m_lvl[i] && m_gl[0] && m_st == 0) pick = i;
      for (int i = 7; i >= 0; i--)
         if (m_flag[i] && m_en[i] && m_lvl[i] && m_gl[1] && m_st < 2) pick = i + 8;
   endfunction

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
      int n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && ++n < 40);
      s_axi_bready <= 1'b0;
      // A wait that ran out shows here as a missing answer
      chk("bvalid", s_axi_bvalid, 1);
      chk("bresp", s_axi_bresp, er);
   endtask

   // Read with a one-cycle stall on rready
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
      int n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready && ++n < 40);
      s_axi_arvalid <= 1'b0;
      @(posedge aclk);
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_rvalid && ++n < 80);
      s_axi_rready <= 1'b0;
      chk("rvalid", s_axi_rvalid, 1);
      chk("rresp", s_axi_rresp, er);
      chk("rdata", s_axi_rdata, e);
   endtask

   task automatic fire_ev(input logic [7:0] b);
      @(posedge aclk);
      fire <= b;
      m_flag = m_flag | b;
      @(posedge aclk);
      fire <= 8'h00;
   endtask

   task automatic expect_take(input int e);
      int n = 0;
      do @(posedge aclk); while (!vector_take && ++n < 30);
      chk("take", vector_take, e >= 0);
      if (e >= 0) begin
         chk("vector", vector_num, e & 7);
         chk("working_register", working_register, e & 7);
         chk("level", vector_high, e >> 3);
         m_st = (e >> 3) ? ((m_st == 1) ? 3 : 2) : 1;
         if ((e & 7) == 0) m_flag[0] = 0;
         stk.push_back(e & 7);
         rd(8'h10, m_st);
         rd(8'h0C, m_gl);
         rd(8'h04, m_flag);
      end
   endtask

   task automatic ret_from(input int v);
      if (v != 7) m_flag[v] = 0;
      wr(8'h04, 32'hFF ^ (32'h1 << v));
      rd(8'h04, m_flag);
      if (v == 7) begin
         rd(8'h24, 32'h80);
         sum_on <= 1'b0;
         m_flag[7] = 0;
         repeat (3) @(posedge aclk);
      end
      // Return by core strobe or by register write, at random
      if ($urandom_range(1)) begin
         wr(8'h18, 1);
      end else begin
         ret_dly <= 4'($urandom_range(7));
         ret_req <= 1'b1;
         @(posedge aclk);
         ret_req <= 1'b0;
      end
      m_st = (m_st == 3) ? 1 : 0;
   endtask

   task automatic drain;
      while (pick() >= 0 || stk.size() > 0)
         if (pick() >= 0) expect_take(pick());
         else ret_from(stk.pop_back());
      expect_take(-1);
   endtask

   // ---------
   // Sequence
   // ---------
   initial begin
      void'($urandom(88));
      m_en = $urandom_range(255);
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h00, 0);
      rd(8'h08, 32'hFF);
      rd(8'h10, 0);
      rd(8'h28, 0, 2'h2);
      wr(8'h14, 1, 2'h2);
      wr(8'h00, m_en);
      rd(8'h00, m_en);
      // Lane 0 strobe low: the write must leave the register alone
      s_axi_wstrb <= 4'hE;
      wr(8'h00, 0);
      s_axi_wstrb <= 4'hF;
      rd(8'h00, m_en);
      wr(8'h02, 1, 2'h2);
      m_en = 255;
      wr(8'h00, m_en);
      m_gl = 3;
      wr(8'h0C, m_gl);
      for (int k = 0; k < 5; k++) begin
         fire_ev((8'h1 << $urandom_range(6)) | (8'h1 << $urandom_range(6)));
         drain;
      end
      m_lvl = 8'h40;
      wr(8'h08, m_lvl);
      fire_ev(8'h42);
      drain;
      fire_ev(8'h02);
      expect_take(pick());
      fire_ev(8'h44);
      drain;
      m_lvl = 255;
      wr(8'h08, m_lvl);
      sum_on <= 1'b1;
      m_flag[7] = 1;
      drain;
      for (int k = 0; k < 3; k++) begin
         m_en = k ? 255 : 0;
         m_gl = k ? k : 3;
         m_lvl = (k == 2) ? 0 : 255;
         wr(8'h00, m_en);
         wr(8'h0C, m_gl);
         wr(8'h08, m_lvl);
         fire_ev(8'h7F);
         expect_take(pick());
         wr(8'h04, 0);
         m_flag = 0;
      end
      m_gl = 3;
      wr(8'h0C, m_gl);
      fire_ev(8'h10);
      expect_take(pick());
      wr(8'h04, 8'hEF);
      m_flag = 0;
      wr(8'h0C, m_gl);
      m_st = 0;
      stk.delete();
      rd(8'h10, 0);
      wr(8'h20, 0);
      chk("irq", irq, 0);
      wr(8'h20, 1);
      repeat (2) @(posedge aclk);
      chk("irq", irq, 1);
      rd(8'h1C, 3);
      wr(8'h1C, 3);
      repeat (2) @(posedge aclk);
      chk("irq", irq, 0);
      end_of_test;
   end

   initial begin
      #400000;
      err_total++;
      end_of_test;
   end
endmodule
